// [pkg/hls_pkg.sv]
// Constants, types and decode functions of the host link supervisor
package hls_pkg;
    // Time base
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;

    // Link supervision times in ms
    localparam int TIMEOUT_MIN_MS = 25;
    localparam int TIMEOUT_MAX_MS = 35;
    localparam int STRETCH_HOST_MS = 10;
    localparam int STRETCH_TGT_MS = 25;
    localparam int WDI_DEGLITCH_MS = 10;

    // Tick counts; one tick more on minimums and one less on the stretch limit covers the unknown phase of the first tick
    localparam logic [7:0] TIMEOUT_TICKS = 8'(TIMEOUT_MIN_MS * 1000 / TICK_US + 1);
    localparam logic [7:0] TIMEOUT_MAX_TICKS = 8'(TIMEOUT_MAX_MS * 1000 / TICK_US);
    localparam logic [7:0] STRETCH_TICKS = 8'(STRETCH_TGT_MS * 1000 / TICK_US - 1);
    localparam logic [3:0] DEGLITCH_TICKS = 4'(WDI_DEGLITCH_MS * 1000 / TICK_US + 1);

    // Watchdog expiry periods in ms
    localparam logic [17:0] WD_MS_01 = 18'd5500;
    localparam logic [17:0] WD_MS_10 = 18'd88000;
    localparam logic [17:0] WD_MS_11 = 18'd175000;

    // Register map
    localparam logic [7:0] REG_CHARGE_OPTION_LOW = 8'h01;
    localparam logic [7:0] CHARGE_OPTION_LOW_RST = 8'h00;
    localparam int WD_FIELD_LSB = 5;
    localparam int WD_FIELD_MSB = 6;

    typedef enum logic [1:0]
    {
        HLS_IDLE    = 2'b00,
        HLS_XFER    = 2'b01,
        HLS_RELEASE = 2'b10
    } hls_link_t;

    // Expiry period for a period code; zero means disabled
    function automatic logic [17:0] hls_wd_limit(input logic [1:0] code);
        logic [17:0] lim;
        lim = 18'h0;
        case (code)
            2'b01: lim = WD_MS_01;
            2'b10: lim = WD_MS_10;
            2'b11: lim = WD_MS_11;
            default: lim = 18'h0;
        endcase
        return lim;
    endfunction : hls_wd_limit
endpackage : hls_pkg

// [pkg/hls_deg_if.sv]
// Carrier between supervisor and watchdog-reset deglitcher
`timescale 1ns/100ps
`default_nettype none
interface hls_deg_if;
    logic tick;
    logic level;
    logic accept;
    modport src (output tick, output level, input accept);
    modport deg (input tick, input level, output accept);
endinterface : hls_deg_if
`default_nettype wire

// [rtl/hls_deglitch.sv]
// Deglitcher for the watchdog reset signal
`timescale 1ns/100ps
`default_nettype none
module hls_deglitch
(
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst_b,
    input  wire logic   clk_en,
    // Carrier
    hls_deg_if.deg      d
);
    logic [3:0] hold_cnt;
    logic       fired;

    // Count ticks while high; short pulses restart from zero
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            hold_cnt <= 4'h0;
            fired    <= 1'b0;
            d.accept <= 1'b0;
        end
        else if (clk_en)
        begin
            d.accept <= 1'b0;
            if (!d.level)
            begin
                hold_cnt <= 4'h0;
                fired    <= 1'b0;
            end
            else if (d.tick && !fired)
            begin
                hold_cnt <= hold_cnt + 4'h1;
                if (hold_cnt + 4'h1 == hls_pkg::DEGLITCH_TICKS)
                begin
                    d.accept <= 1'b1;
                    fired    <= 1'b1; // One accept per assertion
                end
            end
        end
    end

    AST_DEG_ACCEPT: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(d.accept) |-> hold_cnt == hls_pkg::DEGLITCH_TICKS && $past(d.level))
        else $error("watchdog reset accepted before deglitch time");
endmodule : hls_deglitch
`default_nettype wire

// [rtl/hls_supervisor.sv]
// Host link supervisor: bus stall release, stretch budget and host watchdog
// Summary of operation
// - A clock-low period longer than 25 ms marks the transfer as timed out.
// - After a timeout, communication logic is reset well within 35 ms.
// - Clock stretching per transfer: host at most 10 ms, target at most 25 ms; only the target budget is enforced, host stretching is not checked.
// - Period code in bits 6:5 of register 0x01 selects 5.5, 88 or 175 s.
// - Watchdog reset is accepted only after 10 ms present; shorter ones ignored.
`timescale 1ns/100ps
`default_nettype none
module hls_supervisor
#(
    parameter int TICK_CYC = hls_pkg::TICK_CYC
)
(
    // Clock, reset, enable
    input  wire logic       ref_clk,
    input  wire logic       rst_b,
    input  wire logic       clk_en,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe,
    // Watchdog reset pin
    input  wire logic       wdi_in,
    // Register access from the serial front end
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    // Own target logic asks to stretch the clock
    input  wire logic       stretch_req,
    // Status
    output logic            comm_reset,
    output logic            bus_timeout,
    output logic            wd_expired
);
    hls_deg_if dg ();

    logic [2:0]  scl_s;
    logic [2:0]  sda_s;
    logic [1:0]  wdi_s;
    logic [31:0] pre_cnt;
    logic        tick;
    logic [7:0]  low_ticks;
    logic [7:0]  stretch_ticks;
    logic [17:0] wd_ticks;
    logic [7:0]  charge_option_low;
    logic        to_hit;
    logic        wd_hit;
    logic        start_det;
    logic        stop_det;
    logic [1:0]  wd_code;
    hls_pkg::hls_link_t state;
    hls_pkg::hls_link_t next_state;

    // Pin synchronisers; bit 0 is only read by bit 1
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            wdi_s <= 2'h0;
        end
        else if (clk_en)
        begin
            scl_s <= {scl_s[1:0], scl_in};
            sda_s <= {sda_s[1:0], sda_in};
            wdi_s <= {wdi_s[0], wdi_in};
        end
    end

    // Start and stop seen while the clock is high
    assign start_det = scl_s[2] && scl_s[1] && sda_s[2] && !sda_s[1];
    assign stop_det  = scl_s[2] && scl_s[1] && !sda_s[2] && sda_s[1];

    // Millisecond prescaler keeps the long counters narrow
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_cnt <= 32'h0;
            tick    <= 1'b0;
        end
        else if (clk_en)
        begin
            tick    <= (pre_cnt == 32'(TICK_CYC - 1));
            pre_cnt <= (pre_cnt == 32'(TICK_CYC - 1)) ? 32'h0 : pre_cnt + 32'h1;
        end
    end

    // Length of the current clock-low period
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            low_ticks <= 8'h0;
        else if (clk_en)
        begin
            if (scl_s[1] || state == hls_pkg::HLS_RELEASE)
                low_ticks <= 8'h0;
            else if (tick && low_ticks != hls_pkg::TIMEOUT_TICKS)
                low_ticks <= low_ticks + 8'h1;
        end
    end

    assign to_hit = (low_ticks == hls_pkg::TIMEOUT_TICKS) && state != hls_pkg::HLS_RELEASE;

    // Link state; a clock stuck low with no transfer open is released too
    always_comb
    begin
        next_state = state;
        case (state)
            hls_pkg::HLS_IDLE:
                if (to_hit)
                    next_state = hls_pkg::HLS_RELEASE;
                else if (start_det)
                    next_state = hls_pkg::HLS_XFER;
            hls_pkg::HLS_XFER:
                if (to_hit)
                    next_state = hls_pkg::HLS_RELEASE;
                else if (stop_det)
                    next_state = hls_pkg::HLS_IDLE;
            hls_pkg::HLS_RELEASE:
                if (scl_s[1])
                    next_state = hls_pkg::HLS_IDLE;
            default:
                next_state = hls_pkg::HLS_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            state <= hls_pkg::HLS_IDLE;
        else if (clk_en)
            state <= next_state;
    end

    // Reset pulse and timeout level for the serial front end
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            comm_reset  <= 1'b0;
            bus_timeout <= 1'b0;
        end
        else if (clk_en)
        begin
            comm_reset  <= to_hit;
            bus_timeout <= (next_state == hls_pkg::HLS_RELEASE);
        end
    end

    // Stretch budget of this target, restarted per transfer
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stretch_ticks <= 8'h0;
            scl_oe        <= 1'b0;
            scl_out       <= 1'b0;
        end
        else if (clk_en)
        begin
            if (start_det || stop_det)
                stretch_ticks <= 8'h0;
            else if (scl_oe && tick)
                stretch_ticks <= stretch_ticks + 8'h1;
            // Budget spent or bus in release: let the clock go
            scl_oe <= stretch_req && state == hls_pkg::HLS_XFER && !to_hit
                      && !(scl_oe && tick && stretch_ticks + 8'h1 >= hls_pkg::STRETCH_TICKS)
                      && stretch_ticks < hls_pkg::STRETCH_TICKS;
        end
    end

    // Register 0x01 and its read path
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            charge_option_low <= hls_pkg::CHARGE_OPTION_LOW_RST;
            reg_rdata         <= 8'h0;
        end
        else if (clk_en)
        begin
            if (reg_wr && reg_addr == hls_pkg::REG_CHARGE_OPTION_LOW)
                charge_option_low <= reg_wdata;
            reg_rdata <= (reg_addr == hls_pkg::REG_CHARGE_OPTION_LOW) ? charge_option_low : 8'h0;
        end
    end

    assign wd_code = charge_option_low[hls_pkg::WD_FIELD_MSB:hls_pkg::WD_FIELD_LSB];

    // Deglitched watchdog reset
    assign dg.tick  = tick;
    assign dg.level = wdi_s[1];

    hls_deglitch u_deg
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .clk_en  (clk_en),
        .d       (dg.deg)
    );

    assign wd_hit = wd_code != 2'b00 && tick && wd_ticks + 18'h1 == hls_pkg::hls_wd_limit(wd_code);

    // Host watchdog; a period write or accepted reset restarts it
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wd_ticks   <= 18'h0;
            wd_expired <= 1'b0;
        end
        else if (clk_en)
        begin
            if (wd_code == 2'b00 || dg.accept || wd_hit
                || (reg_wr && reg_addr == hls_pkg::REG_CHARGE_OPTION_LOW))
                wd_ticks <= 18'h0;
            else if (tick)
                wd_ticks <= wd_ticks + 18'h1;
            // Expiry wins over a reset arriving in the same cycle
            wd_expired <= wd_hit || (wd_expired && !dg.accept);
        end
    end

    sequence s_low_limit;
        !scl_s[1] && to_hit;
    endsequence

    AST_TIMEOUT_LEN: assert property (@(posedge ref_clk) disable iff (!rst_b)
        $rose(comm_reset) |-> $past(low_ticks) == hls_pkg::TIMEOUT_TICKS)
        else $error("timeout taken at wrong clock-low length");

    AST_RELEASE_BOUND: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en and s_low_limit) |=> comm_reset && bus_timeout && !scl_oe
            && low_ticks <= hls_pkg::TIMEOUT_MAX_TICKS)
        else $error("communication not reset after clock-low timeout");

    AST_STRETCH_BUDGET: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (scl_oe && $past(clk_en)) |-> stretch_ticks < hls_pkg::STRETCH_TICKS && $past(stretch_req))
        else $error("clock stretched beyond target budget");

    AST_WD_PERIOD: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wd_hit) |=> wd_expired && wd_ticks == 18'h0
            && $past(wd_ticks) == hls_pkg::hls_wd_limit($past(wd_code)) - 18'h1)
        else $error("watchdog expired at wrong period");

    AST_WD_KICK: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && dg.accept && !wd_hit) |=> !wd_expired && wd_ticks == 18'h0)
        else $error("accepted watchdog reset did not restart watchdog");

    AST_WD_OFF: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (clk_en && wd_code == 2'b00 && !wd_expired) |=> !wd_expired)
        else $error("watchdog expired while disabled");
endmodule : hls_supervisor
`default_nettype wire

// [sim/hls_host_model.sv]
// Host side of the serial bus: drives clock and data, sees device stretching
`timescale 1ns/100ps
`default_nettype none
module hls_host_model
(
    // Device drive on the clock pin
    input  wire logic scl_oe,
    input  wire logic scl_out,
    // Wire levels
    output logic      scl,
    output logic      sda
);
    logic host_scl = 1'b1;
    logic host_sda = 1'b1;

    // Open-drain lines with pull-ups; either party may pull the clock low, only the host drives data
    assign scl = host_scl & ~(scl_oe & ~scl_out);
    assign sda = host_sda;

    // Start: data falls while the clock is high
    task automatic start();
        host_scl = 1'b1;
        host_sda = 1'b1;
        #40;
        host_sda = 1'b0;
        #40;
    endtask : start

    // Clock pulses of 80 ns; each bit holds the clock low for 40 ns
    task automatic bits(input int n);
        repeat (n)
        begin
            host_scl = 1'b0;
            #40;
            host_scl = 1'b1;
            #40;
        end
    endtask : bits

    // Hold or release the clock line
    task automatic drive_scl(input logic v);
        host_scl = v;
    endtask : drive_scl

    // Stop: data rises while the clock is high
    task automatic stop();
        host_scl = 1'b0;
        host_sda = 1'b0;
        #40;
        host_scl = 1'b1;
        #40;
        host_sda = 1'b1;
        #40;
    endtask : stop
endmodule : hls_host_model
`default_nettype wire

// [sim/host_link_supervisor_bench.sv]
// Self-checking bench of the host link supervisor
`timescale 1ns/100ps
`default_nettype none
module host_link_supervisor_bench;
    // One tick of TK cycles stands for 1 ms
    localparam int TK = 8;
    logic       ref_clk     = 1'b0;
    logic       clk_en      = 1'b1;
    logic       rst_b       = 1'b0;
    logic       wdi_in      = 1'b0;
    logic       reg_wr      = 1'b0;
    logic       stretch_req = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic [7:0] reg_rdata;
    logic       scl_out;
    logic       scl_oe;
    logic       comm_reset;
    logic       bus_timeout;
    logic       wd_expired;
    wire        scl;
    wire        sda;
    int         fail_count  = 0;
    int         comparisons = 0;
    int         n;

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    hls_host_model i_host (.scl_oe(scl_oe), .scl_out(scl_out), .scl(scl), .sda(sda));

    hls_supervisor #(.TICK_CYC(TK)) i_dut
    (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .scl_in(scl), .sda_in(sda),
        .scl_out(scl_out), .scl_oe(scl_oe), .wdi_in(wdi_in), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .stretch_req(stretch_req), .comm_reset(comm_reset), .bus_timeout(bus_timeout),
        .wd_expired(wd_expired)
    );

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Write strobe lasts one cycle
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data lands one cycle after the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        repeat (2) @(posedge ref_clk);
        #1 chk(reg_rdata, exp);
    endtask : rd

    // Bounded wait for a level, counting cycles
    task automatic wait_sig(ref logic s, input logic v, input int lim, output int cyc);
        cyc = 0;
        while (s !== v)
        begin
            @(posedge ref_clk);
            #1 cyc++;
            if (cyc > lim)
            begin
                fail_count++;
                $display("unexpected at %0t: wait ran out", $time);
                end_of_test();
            end
        end
    endtask : wait_sig

    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        #1 chk({comm_reset, bus_timeout, wd_expired, scl_oe, scl_out}, 18'h0);
        // Register map: read back, unmapped address refused
        rd(8'h01, 8'h00);
        wr(8'h01, 8'h60);
        rd(8'h01, 8'h60);
        wr(8'h02, 8'hff);
        rd(8'h02, 8'h00);
        rd(8'h01, 8'h60);
        wr(8'h01, 8'h00);
        // Clock enable low: the write is not taken
        @(posedge ref_clk);
        clk_en <= 1'b0;
        wr(8'h01, 8'h20);
        @(posedge ref_clk);
        clk_en <= 1'b1;
        rd(8'h01, 8'h00);
        $display("test registers done");
        // Clock low for 20 ms is no timeout
        i_host.start();
        i_host.bits(4);
        i_host.drive_scl(1'b0);
        repeat (20 * TK) @(posedge ref_clk);
        #1 chk(bus_timeout, 18'h0);
        i_host.drive_scl(1'b1);
        i_host.stop();
        // Clock stuck low: release between 25 and 27 ms
        i_host.start();
        i_host.drive_scl(1'b0);
        wait_sig(comm_reset, 1'b1, 40 * TK, n);
        chk(18'(n > 25 * TK && n <= 27 * TK), 18'h1);
        chk(bus_timeout, 18'h1);
        @(posedge ref_clk);
        #1 chk(comm_reset, 18'h0);
        i_host.drive_scl(1'b1);
        wait_sig(bus_timeout, 1'b0, 10, n);
        i_host.stop();
        $display("test timeout done");
        // Stretch budget of the target
        i_host.start();
        i_host.bits(2);
        @(posedge ref_clk);
        stretch_req <= 1'b1;
        wait_sig(scl_oe, 1'b1, 4, n);
        chk({scl, scl_out}, 18'h0);
        wait_sig(scl_oe, 1'b0, 30 * TK, n);
        chk(18'(n >= 22 * TK && n <= 25 * TK), 18'h1);
        repeat (2 * TK) @(posedge ref_clk);
        #1 chk(scl_oe, 18'h0);
        @(posedge ref_clk);
        stretch_req <= 1'b0;
        i_host.stop();
        $display("test stretch done");
        // Watchdog code 01 expires near 5.5 s
        wr(8'h01, 8'h20);
        wait_sig(wd_expired, 1'b1, 5600 * TK, n);
        chk(18'(n >= 5498 * TK && n <= 5502 * TK), 18'h1);
        // Short reset pulse is a glitch, a long one is taken
        @(posedge ref_clk);
        wdi_in <= 1'b1;
        repeat (9 * TK) @(posedge ref_clk);
        wdi_in <= 1'b0;
        repeat (4 * TK) @(posedge ref_clk);
        #1 chk(wd_expired, 18'h1);
        @(posedge ref_clk);
        wdi_in <= 1'b1;
        repeat (12 * TK) @(posedge ref_clk);
        wdi_in <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 chk(wd_expired, 18'h0);
        // Code 00: no expiry past the shortest period
        wr(8'h01, 8'h00);
        repeat (5600 * TK) @(posedge ref_clk);
        #1 chk(wd_expired, 18'h0);
        $display("test watchdog done");
        end_of_test();
    end
endmodule : host_link_supervisor_bench
`default_nettype wire
